// ### core/lpe_regs.sv
module lpe_regs #(
   parameter int COOL_SEC_TICKS = lpe_pkg::SEC_TICKS
) (
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [9:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic [7:0]  adc_ch1_in,
   input  wire logic [7:0]  adc_ch2_in,
   output logic [15:0]      reg_rdata_out,
   output logic [7:0]       load_code_ch1_out,
   output logic [7:0]       load_code_ch2_out,
   output logic             surge_ch1_out,
   output logic             surge_ch2_out,
   output logic             cool_ch1_out,
   output logic             cool_ch2_out,
   output logic [3:0]       pga_therm_out
);
   import lpe_pkg::*;

   logic        mode_ff, nxt_mode;
   logic [7:0]  thr_ff, nxt_thr;
   logic [5:0]  low_ff, nxt_low;
   logic [7:0]  scode_ff, nxt_scode;
   logic [11:0] stime_ff, nxt_stime;
   logic [15:0] cctrl_ff, nxt_cctrl;
   logic [15:0] limit_ff, nxt_limit;
   logic [1:0]  en_ff, nxt_en;
   logic [1:0]  gain_ff, nxt_gain;
   logic [3:0]  therm_ff, nxt_therm;
   logic [15:0] rdata_ff, nxt_rdata;

   logic        tick;
   logic [2:0]  tick_idx;
   logic [7:0]  adc [2];
   logic [7:0]  code [2];
   logic        surge [2];
   logic        cool [2];
   logic [15:0] accum [2];

   assign adc[0] = adc_ch1_in;
   assign adc[1] = adc_ch2_in;

   lpe_tick u_tick (
      .core_clk_in  (core_clk_in),
      .rst_n_in     (rst_n_in),
      .tick_out     (tick),
      .tick_idx_out (tick_idx)
   );

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         lpe_chan u_chan (
            .core_clk_in            (core_clk_in),
            .rst_n_in               (rst_n_in),
            .tick_in                (tick),
            .tick_idx_in            (tick_idx),
            .load_on_in             (en_ff[ch]),
            .idle_level_select_in   (mode_ff),
            .adc_in                 (adc[ch]),
            .surge_trigger_level_in (thr_ff),
            .idle_current_level_in  (low_ff),
            .surge_code_in          (scode_ff),
            .surge_time_in          (stime_ff),
            .cool_ctrl_in           (cctrl_ff),
            .energy_limit_value_in  (limit_ff),
            .sec_ticks_in           (20'(COOL_SEC_TICKS)),
            .load_code_out          (code[ch]),
            .surge_out              (surge[ch]),
            .cool_out               (cool[ch]),
            .accum_out              (accum[ch])
         );
      end
   endgenerate

   always_comb begin
      nxt_mode  = mode_ff;
      nxt_thr   = thr_ff;
      nxt_low   = low_ff;
      nxt_scode = scode_ff;
      nxt_stime = stime_ff;
      nxt_cctrl = cctrl_ff;
      nxt_limit = limit_ff;
      nxt_en    = en_ff;
      nxt_gain  = gain_ff;
      if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_MODE: nxt_mode = reg_wdata_in[0];
            ADDR_THR: begin
               nxt_thr = reg_wdata_in[7:0];
               if (reg_wdata_in[7:0] < THR_MIN) nxt_thr = THR_MIN;
               if (reg_wdata_in[7:0] > THR_MAX) nxt_thr = THR_MAX;
            end
            ADDR_LOW: nxt_low = (reg_wdata_in[5:0] == 6'h00) ? 6'h01 : reg_wdata_in[5:0];
            ADDR_SURGE_CODE:
               nxt_scode = (reg_wdata_in[7:0] == 8'h00) ? 8'h01 : reg_wdata_in[7:0];
            ADDR_SURGE_TIME:
               nxt_stime = (reg_wdata_in[11:0] == 12'h000) ? 12'h001
                                                           : reg_wdata_in[11:0];
            ADDR_COOL_CTRL: nxt_cctrl = reg_wdata_in;
            ADDR_LIMIT: nxt_limit = reg_wdata_in;
            ADDR_EN:
               nxt_en = {reg_wdata_in[LOAD_ON_SECOND_BIT], reg_wdata_in[LOAD_ON_FIRST_BIT]};
            ADDR_GAIN: nxt_gain = reg_wdata_in[1:0];
            default: ;
         endcase
      end
      case (gain_ff)
         2'h0:    nxt_therm = 4'h1;
         2'h1:    nxt_therm = 4'h3;
         2'h2:    nxt_therm = 4'h7;
         default: nxt_therm = 4'hf;
      endcase
   end

   // Read data holds between reads so a slow serial shifter can take it at leisure
   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd_in) begin
         case (reg_addr_in)
            ADDR_MODE:       nxt_rdata = {15'h0000, mode_ff};
            ADDR_THR:        nxt_rdata = {8'h00, thr_ff};
            ADDR_LOW:        nxt_rdata = {10'h000, low_ff};
            ADDR_SURGE_CODE: nxt_rdata = {8'h00, scode_ff};
            ADDR_SURGE_TIME: nxt_rdata = {4'h0, stime_ff};
            ADDR_COOL_CTRL:  nxt_rdata = cctrl_ff;
            ADDR_LIMIT:      nxt_rdata = limit_ff;
            ADDR_ACC1:       nxt_rdata = accum[0];
            ADDR_ACC2:       nxt_rdata = accum[1];
            ADDR_EN:         nxt_rdata = {en_ff[1], en_ff[0], 14'h0000};
            ADDR_GAIN:       nxt_rdata = {14'h0000, gain_ff};
            default:         nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_ff  <= 1'b0;
         thr_ff   <= RST_THR;
         low_ff   <= RST_LOW;
         scode_ff <= RST_SURGE_CODE;
         stime_ff <= RST_SURGE_TIME;
         cctrl_ff <= RST_COOL_CTRL;
         limit_ff <= RST_LIMIT;
         en_ff    <= 2'h0;
         gain_ff  <= 2'h0;
         therm_ff <= 4'h1;
         rdata_ff <= 16'h0000;
      end else begin
         mode_ff  <= nxt_mode;
         thr_ff   <= nxt_thr;
         low_ff   <= nxt_low;
         scode_ff <= nxt_scode;
         stime_ff <= nxt_stime;
         cctrl_ff <= nxt_cctrl;
         limit_ff <= nxt_limit;
         en_ff    <= nxt_en;
         gain_ff  <= nxt_gain;
         therm_ff <= nxt_therm;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_out     = rdata_ff;
   assign load_code_ch1_out = code[0];
   assign load_code_ch2_out = code[1];
   assign surge_ch1_out     = surge[0];
   assign surge_ch2_out     = surge[1];
   assign cool_ch1_out      = cool[0];
   assign cool_ch2_out      = cool[1];
   assign pga_therm_out     = therm_ff;

   surge_min_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == ADDR_SURGE_CODE && reg_wdata_in[7:0] == 8'h00)
      |=> scode_ff == 8'h01)
      else $error("surge level zero accepted");
   time_min_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == ADDR_SURGE_TIME && reg_wdata_in[11:0] == 12'h000)
      |=> stime_ff == 12'h001)
      else $error("surge period zero accepted");
   thr_clamp_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == ADDR_THR && reg_wdata_in[7:0] == 8'hff)
      |=> thr_ff == 8'hfe)
      else $error("threshold not clamped");
   load_en_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == ADDR_EN)
      |=> en_ff == {$past(reg_wdata_in[15]), $past(reg_wdata_in[14])})
      else $error("load enable bits misplaced");
   gain_therm_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_wr_in && reg_addr_in == ADDR_GAIN && reg_wdata_in[1:0] == 2'h2)
      |=> ##1 pga_therm_out == 4'h7)
      else $error("gain decode wrong");
   acc_read_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (reg_rd_in && reg_addr_in == ADDR_ACC2) |=> reg_rdata_out == $past(accum[1]))
      else $error("accumulator readback wrong");
endmodule

// ### core/lpe_pkg.sv
package lpe_pkg;
   localparam logic [9:0]  ADDR_MODE       = 10'h010;
   localparam logic [9:0]  ADDR_THR        = 10'h011;
   localparam logic [9:0]  ADDR_LOW        = 10'h012;
   localparam logic [9:0]  ADDR_SURGE_CODE = 10'h013;
   localparam logic [9:0]  ADDR_SURGE_TIME = 10'h014;
   localparam logic [9:0]  ADDR_COOL_CTRL  = 10'h015;
   localparam logic [9:0]  ADDR_LIMIT      = 10'h016;
   localparam logic [9:0]  ADDR_ACC1       = 10'h017;
   localparam logic [9:0]  ADDR_ACC2       = 10'h018;
   localparam logic [9:0]  ADDR_EN         = 10'h200;
   localparam logic [9:0]  ADDR_GAIN       = 10'h201;

   localparam logic [7:0]  RST_SURGE_CODE  = 8'hc8;
   localparam logic [11:0] RST_SURGE_TIME  = 12'h12c;
   localparam logic [15:0] RST_COOL_CTRL   = 16'h0505;
   localparam logic [15:0] RST_LIMIT       = 16'h9ba3;
   localparam logic [7:0]  RST_THR         = 8'h1e;
   localparam logic [5:0]  RST_LOW         = 6'h1e;

   localparam logic [7:0]  THR_MIN         = 8'h01;
   localparam logic [7:0]  THR_MAX         = 8'hfe;
   localparam logic [7:0]  ADC_FULL        = 8'hff;

   localparam int          LOAD_ON_SECOND_BIT = 15;
   localparam int          LOAD_ON_FIRST_BIT  = 14;
   localparam int          DECR_LSB        = 8;
   localparam int          SCALE_LSB       = 6;
   localparam int          STEP_LSB        = 4;
   localparam int          SEC_LSB         = 0;

   localparam int          ACC_W           = 24;
   localparam int          ACC_SHIFT       = 7;
   localparam int          COOL_W          = 24;

   localparam int          CLK_MHZ         = 50;
   localparam int          TICK_US         = 10;
   localparam int          SEC_US          = 1000000;
   localparam int          TICK_CYCLES     = CLK_MHZ * TICK_US;
   localparam int          SEC_TICKS       = SEC_US / TICK_US;

   typedef enum logic [1:0] {LPE_OFF, LPE_LOW, LPE_SURGE, LPE_AFTER} lpe_state_t;

   // Step code k means one decrement every 2**k ticks
   function automatic logic [2:0] lpe_step_mask(input logic [1:0] code);
      lpe_step_mask = 3'((4'h1 << code) - 4'h1);
   endfunction
endpackage

// ### core/lpe_tick.sv
module lpe_tick (
   input  wire logic       core_clk_in,
   input  wire logic       rst_n_in,
   output logic            tick_out,
   output logic [2:0]      tick_idx_out
);
   import lpe_pkg::*;

   localparam logic [8:0] TICK_LAST = 9'(TICK_CYCLES - 1);

   logic [8:0] div_ff;
   logic [8:0] nxt_div;
   logic       tick_ff;
   logic       nxt_tick;
   logic [2:0] idx_ff;
   logic [2:0] nxt_idx;

   always_comb begin
      nxt_div  = div_ff + 9'h001;
      nxt_tick = 1'b0;
      nxt_idx  = idx_ff;
      if (div_ff == TICK_LAST) begin
         nxt_div  = 9'h000;
         nxt_tick = 1'b1;
         nxt_idx  = idx_ff + 3'h1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_ff  <= 9'h000;
         tick_ff <= 1'b0;
         idx_ff  <= 3'h0;
      end else begin
         div_ff  <= nxt_div;
         tick_ff <= nxt_tick;
         idx_ff  <= nxt_idx;
      end
   end

   assign tick_out     = tick_ff;
   assign tick_idx_out = idx_ff;

   tick_gap_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      tick_ff |=> (!tick_ff) [*8])
      else $error("tick pulses too close");
endmodule

// ### core/lpe_chan.sv
module lpe_chan (
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        tick_in,
   input  wire logic [2:0]  tick_idx_in,
   input  wire logic        load_on_in,
   input  wire logic        idle_level_select_in,
   input  wire logic [7:0]  adc_in,
   input  wire logic [7:0]  surge_trigger_level_in,
   input  wire logic [5:0]  idle_current_level_in,
   input  wire logic [7:0]  surge_code_in,
   input  wire logic [11:0] surge_time_in,
   input  wire logic [15:0] cool_ctrl_in,
   input  wire logic [15:0] energy_limit_value_in,
   input  wire logic [19:0] sec_ticks_in,
   output logic [7:0]       load_code_out,
   output logic             surge_out,
   output logic             cool_out,
   output logic [15:0]      accum_out
);
   import lpe_pkg::*;

   lpe_state_t         state_ff, nxt_state;
   logic [11:0]        time_ff, nxt_time;
   logic [7:0]         code_ff, nxt_code;
   logic [ACC_W-1:0]   acc_ff, nxt_acc;
   logic               cool_ff, nxt_cool;
   logic               surge_ff, nxt_surge;
   logic [COOL_W-1:0]  ccnt_ff, nxt_ccnt;

   logic [7:0]  decr;
   logic [1:0]  scale;
   logic [1:0]  step_code;
   logic [3:0]  sec;
   logic [11:0] sample;
   logic        live;
   logic        want_surge;
   logic        step;
   logic [ACC_W:0] sum;

   assign decr      = cool_ctrl_in[DECR_LSB +: 8];
   assign scale     = cool_ctrl_in[SCALE_LSB +: 2];
   assign step_code = cool_ctrl_in[STEP_LSB +: 2];
   assign sec       = cool_ctrl_in[SEC_LSB +: 4];
   assign live      = load_on_in && (adc_in != 8'h00);
   // Cool-down holds the surge off, which is what protects the FET
   assign want_surge = live && !cool_ff &&
                       (idle_level_select_in || (adc_in > surge_trigger_level_in));
   assign step = tick_in && ((tick_idx_in & lpe_step_mask(step_code)) == 3'h0);

   always_comb begin
      sample = {4'h0, adc_in};
      if (adc_in == ADC_FULL) begin
         case (scale)
            2'h0:    sample = {4'h0, adc_in};
            2'h1:    sample = {2'h0, adc_in, 2'h0};
            2'h2:    sample = {1'b0, adc_in, 3'h0};
            default: sample = {adc_in, 4'h0};
         endcase
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_time  = time_ff;
      case (state_ff)
         LPE_OFF: begin
            if (want_surge) begin
               nxt_state = LPE_SURGE;
               nxt_time  = surge_time_in;
            end else if (live) begin
               nxt_state = LPE_LOW;
            end
         end
         LPE_LOW: begin
            if (!live) begin
               nxt_state = LPE_OFF;
            end else if (want_surge) begin
               nxt_state = LPE_SURGE;
               nxt_time  = surge_time_in;
            end
         end
         LPE_SURGE: begin
            if (!live) begin
               nxt_state = LPE_OFF;
            end else if (cool_ff) begin
               nxt_state = LPE_AFTER;
            end else if (tick_in) begin
               if (time_ff <= 12'h001) begin
                  nxt_state = LPE_AFTER;
               end else begin
                  nxt_time = time_ff - 12'h001;
               end
            end
         end
         LPE_AFTER: begin
            // Re-arm only after the sample has fallen back to the threshold
            if (!live) begin
               nxt_state = LPE_OFF;
            end else if (!idle_level_select_in && adc_in <= surge_trigger_level_in) begin
               nxt_state = LPE_LOW;
            end
         end
         default: nxt_state = LPE_OFF;
      endcase
      case (nxt_state)
         LPE_SURGE: nxt_code = surge_code_in;
         LPE_OFF:   nxt_code = 8'h00;
         default:   nxt_code = {2'h0, idle_current_level_in};
      endcase
      nxt_surge = (nxt_state == LPE_SURGE);
   end

   always_comb begin
      nxt_acc  = acc_ff;
      nxt_cool = cool_ff;
      nxt_ccnt = ccnt_ff;
      sum      = {1'b0, acc_ff} + {13'h0000, sample};
      if (state_ff == LPE_SURGE) begin
         if (tick_in && !cool_ff) begin
            nxt_acc = sum[ACC_W] ? {ACC_W{1'b1}} : sum[ACC_W-1:0];
         end
      end else if (step) begin
         nxt_acc = (acc_ff > {16'h0000, decr}) ? acc_ff - {16'h0000, decr}
                                               : {ACC_W{1'b0}};
      end
      if (sec == 4'h0) begin
         nxt_cool = 1'b0;
         nxt_ccnt = {COOL_W{1'b0}};
      end else if (!cool_ff) begin
         if (acc_ff > {1'b0, energy_limit_value_in, 7'h00}) begin
            nxt_cool = 1'b1;
            // Widen before the product: fifteen seconds of ticks overflow 20 bits
            nxt_ccnt = COOL_W'(sec) * COOL_W'(sec_ticks_in);
         end
      end else if (tick_in) begin
         if (ccnt_ff <= {{(COOL_W-1){1'b0}}, 1'b1}) begin
            nxt_cool = 1'b0;
         end
         nxt_ccnt = (ccnt_ff == {COOL_W{1'b0}}) ? ccnt_ff : ccnt_ff - 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= LPE_OFF;
         time_ff  <= 12'h000;
         code_ff  <= 8'h00;
         surge_ff <= 1'b0;
         acc_ff   <= {ACC_W{1'b0}};
         cool_ff  <= 1'b0;
         ccnt_ff  <= {COOL_W{1'b0}};
      end else begin
         state_ff <= nxt_state;
         time_ff  <= nxt_time;
         code_ff  <= nxt_code;
         surge_ff <= nxt_surge;
         acc_ff   <= nxt_acc;
         cool_ff  <= nxt_cool;
         ccnt_ff  <= nxt_ccnt;
      end
   end

   assign load_code_out = code_ff;
   // Own flop so the pin never glitches on a state decode
   assign surge_out     = surge_ff;
   assign cool_out      = cool_ff;
   assign accum_out     = acc_ff[ACC_SHIFT +: 16];

   surge_end_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_ff == LPE_SURGE && tick_in && time_ff == 12'h001) |=> state_ff != LPE_SURGE)
      else $error("surge outlived its period");
   cool_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (sec == 4'h0) |=> !cool_ff)
      else $error("cool-down active while disabled");
   cool_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      cool_ff |=> acc_ff <= $past(acc_ff))
      else $error("accumulated during cool-down");
   decr_step_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (state_ff != LPE_SURGE && step && acc_ff > {16'h0000, decr})
      |=> acc_ff == $past(acc_ff) - {16'h0000, $past(decr)})
      else $error("cool-down decrement wrong");
endmodule

// ### verification/lpe_host.sv
module lpe_host (
   input  wire logic        clk_in,
   input  wire logic [15:0] rdata_in,
   output logic             wr_out,
   output logic             rd_out,
   output logic [9:0]       addr_out,
   output logic [15:0]      wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 10'h000;
      wdata_out = 16'h0000;
   end

   // One strobe cycle per access, launched just after an edge
   task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_out <= 1'b1;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask

   // Data is registered, so it is taken just after the strobe's edge
   task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
      @(posedge clk_in);
      rd_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask
endmodule

// ### verification/lpe_regs_tb.sv
module lpe_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lpe_pkg::*;

   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr, rd;
   logic [9:0]  addr;
   logic [15:0] wdata, rdata, a, b;
   logic [7:0]  adc1 = 8'h00, adc2 = 8'h00, code1, code2;
   logic        surge1, surge2, cool1, cool2;
   logic [3:0]  therm;
   int          n_errors = 0;
   int          checks = 0;
   int          n;
   logic [9:0]  ra [11] = '{10'h010, 10'h011, 10'h012, 10'h013, 10'h014, 10'h015,
                             10'h016, 10'h017, 10'h018, 10'h200, 10'h201};
   logic [15:0] rv [11] = '{16'h0000, 16'h001e, 16'h001e, 16'h00c8, 16'h012c, 16'h0505,
                             16'h9ba3, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   always #10 core_clk = ~core_clk;

   lpe_host i_lpe_host (
      .clk_in    (core_clk),
      .rdata_in  (rdata),
      .wr_out    (wr),
      .rd_out    (rd),
      .addr_out  (addr),
      .wdata_out (wdata)
   );

   // Ten ticks to the second keeps cool-down periods short
   lpe_regs #(.COOL_SEC_TICKS(10)) i_lpe_regs (
      .core_clk_in       (core_clk),
      .rst_n_in          (rst_n),
      .reg_wr_in         (wr),
      .reg_rd_in         (rd),
      .reg_addr_in       (addr),
      .reg_wdata_in      (wdata),
      .adc_ch1_in        (adc1),
      .adc_ch2_in        (adc2),
      .reg_rdata_out     (rdata),
      .load_code_ch1_out (code1),
      .load_code_ch2_out (code2),
      .surge_ch1_out     (surge1),
      .surge_ch2_out     (surge2),
      .cool_ch1_out      (cool1),
      .cool_ch2_out      (cool2),
      .pga_therm_out     (therm)
   );

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rchk(input logic [9:0] ad, input logic [15:0] exp);
      logic [15:0] d;
      i_lpe_host.rd_reg(ad, d);
      chk($sformatf("reg %h", ad), exp, d);
   endtask

   task automatic wait_surge1(input logic lvl);
      for (n = 0; n < 3000 && surge1 !== lvl; n++) begin
         @(posedge core_clk);
         #1;
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // About twice the 20000 cycles the sequence needs
   initial begin
      repeat (40000) @(posedge core_clk);
      n_errors++;
      stop_test();
   end

   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 11; i++) rchk(ra[i], rv[i]);
      rchk(10'h3ff, 16'h0000);
      $display("test reset values done");

      i_lpe_host.wr_reg(ADDR_SURGE_CODE, 16'h0000);
      rchk(ADDR_SURGE_CODE, 16'h0001);
      i_lpe_host.wr_reg(ADDR_SURGE_TIME, 16'hffff);
      rchk(ADDR_SURGE_TIME, 16'h0fff);
      i_lpe_host.wr_reg(ADDR_SURGE_TIME, 16'h0000);
      rchk(ADDR_SURGE_TIME, 16'h0001);
      i_lpe_host.wr_reg(ADDR_THR, 16'h0000);
      rchk(ADDR_THR, 16'h0001);
      i_lpe_host.wr_reg(ADDR_THR, 16'h00ff);
      rchk(ADDR_THR, 16'h00fe);
      i_lpe_host.wr_reg(ADDR_ACC1, 16'h1234);
      rchk(ADDR_ACC1, 16'h0000);
      i_lpe_host.wr_reg(ADDR_EN, 16'hffff);
      rchk(ADDR_EN, 16'hc000);
      i_lpe_host.wr_reg(ADDR_EN, 16'h0000);
      for (int g = 0; g < 4; g++) begin
         i_lpe_host.wr_reg(ADDR_GAIN, 16'(g));
         settle();
         chk("therm", 16'((5'h02 << g) - 5'h01), {12'h000, therm});
      end
      $display("test clamps and fields done");

      // Idle-low channel 2 at the threshold boundary
      i_lpe_host.wr_reg(ADDR_THR, 16'h0020);
      i_lpe_host.wr_reg(ADDR_SURGE_TIME, 16'h0003);
      adc2 <= 8'h20;
      i_lpe_host.wr_reg(ADDR_EN, 16'h8000);
      settle();
      chk("code2 low", 16'h001e, {8'h00, code2});
      chk("surge2 low", 16'h0000, {15'h0, surge2});
      @(posedge core_clk);
      adc2 <= 8'h21;
      settle();
      chk("surge2 high", 16'h0001, {15'h0, surge2});
      chk("code2 surge", 16'h0001, {8'h00, code2});
      @(posedge core_clk);
      adc2 <= 8'h00;
      settle();
      chk("code2 off", 16'h0000, {8'h00, code2});
      i_lpe_host.wr_reg(ADDR_EN, 16'h0000);
      $display("test idle low done");

      // Full scale x16 over three ticks: 3*0xff0 = 12240, shown 95
      i_lpe_host.wr_reg(ADDR_COOL_CTRL, 16'h05c5);
      i_lpe_host.wr_reg(ADDR_MODE, 16'h0001);
      adc1 <= 8'hff;
      i_lpe_host.wr_reg(ADDR_EN, 16'h4000);
      wait_surge1(1'b1);
      chk("code1 surge", 16'h0001, {8'h00, code1});
      wait_surge1(1'b0);
      chk("surge span", 16'h0001, {15'h0, n >= 1000 && n <= 1502});
      settle();
      chk("code1 after", 16'h001e, {8'h00, code1});
      rchk(ADDR_ACC1, 16'h005f);
      i_lpe_host.wr_reg(ADDR_LIMIT, 16'h0060);
      settle();
      chk("cool below", 16'h0000, {15'h0, cool1});
      i_lpe_host.wr_reg(ADDR_LIMIT, 16'h005f);
      settle();
      chk("cool above", 16'h0001, {15'h0, cool1});
      chk("cool2 quiet", 16'h0000, {15'h0, cool2});
      i_lpe_host.wr_reg(ADDR_COOL_CTRL, 16'h05c0);
      settle();
      chk("cool off", 16'h0000, {15'h0, cool1});
      $display("test surge and limit done");

      // Eight ticks per window; drop of 2040 >> k allows one count of rounding
      for (int k = 0; k < 4; k++) begin
         i_lpe_host.wr_reg(ADDR_COOL_CTRL, {8'hff, 2'b11, 2'(k), 4'h0});
         i_lpe_host.rd_reg(ADDR_ACC1, a);
         repeat (3998) @(posedge core_clk);
         i_lpe_host.rd_reg(ADDR_ACC1, b);
         n = ((2040 >> k) / 128);
         chk("drop", 16'h0001, {15'h0, (a - b) == n || (a - b) == n + 1});
      end
      rchk(ADDR_ACC2, 16'h0000);
      $display("test cool-down steps done");

      // One surge tick for each of scale codes 0 to 2, no decrement; 255 x factor allows one count of rounding
      i_lpe_host.wr_reg(ADDR_SURGE_TIME, 16'h0001);
      for (int s = 0; s < 3; s++) begin
         i_lpe_host.wr_reg(ADDR_COOL_CTRL, {8'h00, 2'(s), 6'h00});
         adc1 <= 8'h00;
         i_lpe_host.rd_reg(ADDR_ACC1, a);
         @(posedge core_clk);
         adc1 <= 8'hff;
         wait_surge1(1'b1);
         wait_surge1(1'b0);
         i_lpe_host.rd_reg(ADDR_ACC1, b);
         n = ((s == 0) ? 255 : (510 << s)) / 128;
         chk("scale", 16'h0001, {15'h0, (b - a) == n || (b - a) == n + 1});
      end
      $display("test scale codes done");
      stop_test();
   end
endmodule
